// ### logic/rerr_flags.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - channel-status CRC and parity flags read 1 on error, 0 otherwise
// - validity flag mirrors received validity bit: 1 means non-valid
// - biphase flag reads 1 on a biphase-mark coding violation
// - subcode change flag set when new subcode data differs from last
// - lock loss flag is 1 unless decoder and recovery pll both locked
// - subcode crc flag reads 1 when the subcode crc check fails
// - buffer transfer flag reads 1 once copy to user buffer completes
// - slip flag set when output sample to a serial port slips or repeats
// - slip interrupt only for receiver-fed port running as slave
// - with one receiver-fed port, slip is judged on that port
// - with both ports receiver-fed, slip is judged on port a only
// - slip may occur when frame clock edge is within 5 percent window
// - flag interrupt at 0x14 needs its enable bit at 0x16 set
// - slip interrupt needs bit 0 of enable register 0x17 set
// - eight read-only flags in 0x14, bit 7 to 0 in fixed order
// - slip flag in bit 0 of 0x15, bits 7 to 1 read zero
// - each bit of 0x16 gates the flag of the same bit position
// - enable bit 0 masks, 1 enables, reset value 0
// - two-bit trigger field: rise, fall, level, reserved
module rerr_flags
   import rerr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire rerr_req_t reg_req,
   output logic [7:0] reg_rdata_q,
   input wire logic cs_crc_fail,
   input wire logic parity_fail,
   input wire logic validity_in,
   input wire logic biphase_fail,
   input wire logic subcode_valid,
   input wire logic [RERR_SUBCODE_W-1:0] subcode_data,
   input wire logic subcode_crc_fail,
   input wire logic decoder_locked,
   input wire logic recovery_pll_locked,
   input wire logic xfer_start,
   input wire logic xfer_done,
   input wire logic rx_frame_tick,
   input wire logic port_a_frame_edge,
   input wire logic port_b_frame_edge,
   input wire logic port_a_from_rx,
   input wire logic port_b_from_rx,
   input wire logic port_a_slave,
   input wire logic port_b_slave,
   output logic irq_q
);

   rerr_flags_t flags_q;
   rerr_flags_t flags_d;
   logic output_slip_err_q;
   logic [7:0] int_en1_q;
   logic output_slip_err_en_q;
   logic [7:0] int_mode_q;
   logic [RERR_SUBCODE_W-1:0] subcode_prev_q;
   logic slip_evt;
   logic [RERR_NUM_SRC-1:0] trig_hit;
   logic [RERR_NUM_SRC-1:0] trig_src;
   logic [RERR_NUM_SRC-1:0] trig_en;
   logic [RERR_MODE_W-1:0] trig_mode [RERR_NUM_SRC];

   // register decode
   wire logic hit_flags = reg_req.addr == RERR_ADDR_ERR_FLAGS;
   wire logic hit_slip = reg_req.addr == RERR_ADDR_SLIP_FLAG;
   wire logic hit_en1 = reg_req.addr == RERR_ADDR_INT_EN1;
   wire logic hit_en2 = reg_req.addr == RERR_ADDR_INT_EN2;
   wire logic hit_mode = reg_req.addr == RERR_ADDR_INT_MODE;
   wire logic wr_en1 = reg_req.wr & hit_en1;
   wire logic wr_en2 = reg_req.wr & hit_en2;
   wire logic wr_mode = reg_req.wr & hit_mode;
   wire logic rd_slip = reg_req.rd & hit_slip;

   wire logic [7:0] slip_byte = {7'h00, output_slip_err_q};
   wire logic [7:0] en2_byte = {7'h00, output_slip_err_en_q};
   wire logic [7:0] rd_mux = hit_flags ? flags_q :
                             hit_slip ? slip_byte :
                             hit_en1 ? int_en1_q :
                             hit_en2 ? en2_byte :
                             hit_mode ? int_mode_q : RERR_BYTE_ZERO;

   // subcode comparison against the last accepted block
   wire logic subcode_differs = subcode_data != subcode_prev_q;
   wire logic rx_locked = decoder_locked & recovery_pll_locked;

   always_comb begin
      flags_d = flags_q;
      flags_d.chan_status_crc_err = cs_crc_fail;
      flags_d.parity_err = parity_fail;
      flags_d.validity_flag = validity_in;
      flags_d.biphase_err = biphase_fail;
      flags_d.lock_loss = ~rx_locked;
      if (subcode_valid) begin
         flags_d.subcode_changed = subcode_differs;
         flags_d.subcode_crc_err = subcode_crc_fail;
      end
      // completion wins over a new start in the same cycle
      if (xfer_done) flags_d.buffer_transfer_done = 1'b1;
      else if (xfer_start) flags_d.buffer_transfer_done = 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= '0;
         subcode_prev_q <= '0;
      end else begin
         flags_q <= flags_d;
         if (subcode_valid) subcode_prev_q <= subcode_data;
      end
   end

   // slip detection, port selection lives in the submodule
   rerr_slip u_slip (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .rx_frame_tick(rx_frame_tick),
      .port_a_frame_edge(port_a_frame_edge),
      .port_b_frame_edge(port_b_frame_edge),
      .port_a_from_rx(port_a_from_rx),
      .port_b_from_rx(port_b_from_rx),
      .port_a_slave(port_a_slave),
      .port_b_slave(port_b_slave),
      .slip_evt_q(slip_evt)
   );

   // slip flag is sticky until read; a new slip beats the read clear
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) output_slip_err_q <= 1'b0;
      else if (slip_evt) output_slip_err_q <= 1'b1;
      else if (rd_slip) output_slip_err_q <= 1'b0;
   end

   // host-writable enables and trigger modes
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         int_en1_q <= RERR_EN1_RST;
         output_slip_err_en_q <= RERR_EN2_RST;
         int_mode_q <= RERR_MODE_RST;
      end else begin
         if (wr_en1) int_en1_q <= reg_req.wdata;
         if (wr_en2) output_slip_err_en_q <= reg_req.wdata[RERR_SLIP_BIT];
         if (wr_mode) int_mode_q <= reg_req.wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) reg_rdata_q <= RERR_BYTE_ZERO;
      else if (reg_req.rd) reg_rdata_q <= rd_mux;
   end

   // source vector: eight status flags, then the slip flag on top
   assign trig_src = {output_slip_err_q, flags_q};
   assign trig_en = {output_slip_err_en_q, int_en1_q};

   // the low four flags take their mode field, the rest fire on rise
   genvar gi;
   generate
      for (gi = 0; gi < RERR_NUM_SRC; gi++) begin : g_trig
         if (gi < RERR_NUM_MODED) begin : g_moded
            assign trig_mode[gi] = int_mode_q[gi*RERR_MODE_W +: RERR_MODE_W];
         end else begin : g_fixed
            assign trig_mode[gi] = RERR_TRIG_RISE;
         end
         rerr_trig u_trig (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .flag(trig_src[gi]),
            .mode(trig_mode[gi]),
            .hit(trig_hit[gi])
         );
      end
   endgenerate

   // edge modes give a one-cycle pulse, level mode follows the flag
   wire logic irq_d = |(trig_hit & trig_en);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) irq_q <= 1'b0;
      else irq_q <= irq_d;
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   property p_crc_parity;
      ##1 flags_q.chan_status_crc_err == $past(cs_crc_fail) &&
         flags_q.parity_err == $past(parity_fail);
   endproperty
   a_crc_parity: assert property (p_crc_parity)
      else $error("crc or parity flag does not follow its source");

   property p_validity;
      ##1 flags_q.validity_flag == $past(validity_in);
   endproperty
   a_validity: assert property (p_validity)
      else $error("validity flag does not follow received bit");

   property p_biphase;
      biphase_fail |=> flags_q.biphase_err;
   endproperty
   a_biphase: assert property (p_biphase)
      else $error("biphase error not flagged");

   property p_subcode_change;
      subcode_valid && subcode_differs |=> flags_q.subcode_changed
         ##0 (subcode_prev_q == $past(subcode_data));
   endproperty
   a_subcode_change: assert property (p_subcode_change)
      else $error("subcode change not flagged");

   property p_lock_loss;
      (!decoder_locked || !recovery_pll_locked) |=> flags_q.lock_loss;
   endproperty
   a_lock_loss: assert property (p_lock_loss)
      else $error("lock loss not flagged");

   property p_subcode_crc;
      subcode_valid |=> flags_q.subcode_crc_err == $past(subcode_crc_fail);
   endproperty
   a_subcode_crc: assert property (p_subcode_crc)
      else $error("subcode crc flag wrong");

   property p_xfer;
      xfer_done |=> flags_q.buffer_transfer_done;
   endproperty
   a_xfer: assert property (p_xfer)
      else $error("buffer transfer completion lost");

   property p_slip_sticky;
      slip_evt |=> output_slip_err_q ##1 (output_slip_err_q || $past(rd_slip));
   endproperty
   a_slip_sticky: assert property (p_slip_sticky)
      else $error("slip flag lost before read");

   property p_slip_route;
      slip_evt |-> $past(port_a_from_rx ? port_a_slave :
                         port_b_from_rx && port_b_slave);
   endproperty
   a_slip_route: assert property (p_slip_route)
      else $error("slip raised for port not fed or not slave");

   property p_slip_read;
      rd_slip |=> reg_rdata_q[7:1] == 7'h00;
   endproperty
   a_slip_read: assert property (p_slip_read)
      else $error("upper slip register bits not zero");

   property p_masked;
      (int_en1_q == RERR_BYTE_ZERO && !output_slip_err_en_q) |=> !irq_q;
   endproperty
   a_masked: assert property (p_masked)
      else $error("interrupt with all enables clear");

   sequence s_level_set;
      wr_mode && reg_req.wdata[1:0] == RERR_TRIG_LEVEL;
   endsequence
   sequence s_level_hold;
      (int_en1_q[0] && flags_q.buffer_transfer_done) [*2];
   endsequence

   property p_level_irq;
      s_level_set ##1 s_level_hold |=> irq_q;
   endproperty
   a_level_irq: assert property (p_level_irq)
      else $error("level-mode flag did not hold interrupt");

   property p_rise_irq;
      int_en1_q[7] && int_en1_q == $past(int_en1_q) &&
         $rose(flags_q.chan_status_crc_err) |=> irq_q;
   endproperty
   a_rise_irq: assert property (p_rise_irq)
      else $error("rising flag with enable set gave no interrupt");

   property p_slip_edge;
      slip_evt |->
         $past(port_a_from_rx ? port_a_frame_edge : port_b_frame_edge);
   endproperty
   a_slip_edge: assert property (p_slip_edge)
      else $error("slip raised without an edge on the judged port");

   property p_slip_clear;
      rd_slip && !slip_evt |=> !output_slip_err_q;
   endproperty
   a_slip_clear: assert property (p_slip_clear)
      else $error("slip flag not cleared by its read");

   property p_flags_read;
      reg_req.rd && hit_flags |=> reg_rdata_q == $past(flags_q);
   endproperty
   a_flags_read: assert property (p_flags_read)
      else $error("flag register read returned a wrong byte");

   property p_slip_bit;
      rd_slip |=> reg_rdata_q[RERR_SLIP_BIT] == $past(output_slip_err_q);
   endproperty
   a_slip_bit: assert property (p_slip_bit)
      else $error("slip register read lost the flag");

   property p_en1_write;
      wr_en1 |=> int_en1_q == $past(reg_req.wdata);
   endproperty
   a_en1_write: assert property (p_en1_write)
      else $error("enable register write not taken");

   property p_en2_write;
      wr_en2 |=>
         output_slip_err_en_q == $past(reg_req.wdata[RERR_SLIP_BIT]);
   endproperty
   a_en2_write: assert property (p_en2_write)
      else $error("slip enable write not taken");

   property p_reserved;
      trig_mode[1] == RERR_TRIG_RSVD |-> !trig_hit[1];
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved trigger mode fired");

   property p_fall_irq;
      trig_en[0] && trig_mode[0] == RERR_TRIG_FALL &&
         $fell(flags_q.buffer_transfer_done) |=> irq_q;
   endproperty
   a_fall_irq: assert property (p_fall_irq)
      else $error("falling flag in fall mode gave no interrupt");

   property p_irq_cause;
      irq_q |-> $past(trig_en != '0);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt raised with every enable clear");

   property p_locked;
      decoder_locked && recovery_pll_locked |=> !flags_q.lock_loss;
   endproperty
   a_locked: assert property (p_locked)
      else $error("lock loss flag set while locked");

   property p_xfer_clear;
      xfer_start && !xfer_done |=> !flags_q.buffer_transfer_done;
   endproperty
   a_xfer_clear: assert property (p_xfer_clear)
      else $error("buffer transfer flag not cleared on a new start");

   property p_subcode_hold;
      !subcode_valid |=>
         $stable({flags_q.subcode_changed, flags_q.subcode_crc_err});
   endproperty
   a_subcode_hold: assert property (p_subcode_hold)
      else $error("subcode flags moved without a new block");

   property p_en_reset;
      $rose(rst_n) |-> int_en1_q == RERR_EN1_RST &&
         output_slip_err_en_q == RERR_EN2_RST &&
         int_mode_q == RERR_MODE_RST;
   endproperty
   a_en_reset: assert property (p_en_reset)
      else $error("enables or modes not cleared by reset");

endmodule : rerr_flags
`default_nettype wire

// ### logic/rerr_pkg.sv
`default_nettype none
package rerr_pkg;

   // register map
   localparam logic [7:0] RERR_ADDR_ERR_FLAGS = 8'h14;
   localparam logic [7:0] RERR_ADDR_SLIP_FLAG = 8'h15;
   localparam logic [7:0] RERR_ADDR_INT_EN1 = 8'h16;
   localparam logic [7:0] RERR_ADDR_INT_EN2 = 8'h17;
   localparam logic [7:0] RERR_ADDR_INT_MODE = 8'h18;

   localparam logic [7:0] RERR_BYTE_ZERO = 8'h00;
   localparam logic [7:0] RERR_EN1_RST = 8'h00;
   localparam logic [7:0] RERR_MODE_RST = 8'h00;
   localparam logic RERR_EN2_RST = 1'b0;

   // bit positions of the slip enable, the trigger fields and the sources
   localparam int RERR_SLIP_BIT = 0;
   localparam int RERR_NUM_FLAGS = 8;
   localparam int RERR_NUM_SRC = 9;
   localparam int RERR_NUM_MODED = 4;
   localparam int RERR_MODE_W = 2;

   // trigger mode encodings
   localparam logic [1:0] RERR_TRIG_RISE = 2'h0;
   localparam logic [1:0] RERR_TRIG_FALL = 2'h1;
   localparam logic [1:0] RERR_TRIG_LEVEL = 2'h2;
   localparam logic [1:0] RERR_TRIG_RSVD = 2'h3;

   // slip window: edge within this percentage of the frame period
   localparam int RERR_SUBCODE_W = 80;
   localparam int RERR_PHASE_W = 16;
   localparam logic [6:0] RERR_SLIP_WIN_PCT = 7'h05;
   localparam logic [6:0] RERR_PCT_FULL = 7'h64;
   localparam logic [15:0] RERR_PHASE_ONE = 16'h0001;
   localparam logic [15:0] RERR_PHASE_MAX = 16'hffff;

   typedef struct packed {
      logic chan_status_crc_err;
      logic parity_err;
      logic validity_flag;
      logic biphase_err;
      logic subcode_changed;
      logic lock_loss;
      logic subcode_crc_err;
      logic buffer_transfer_done;
   } rerr_flags_t;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } rerr_req_t;

endpackage : rerr_pkg
`default_nettype wire

// ### logic/rerr_slip.sv
`timescale 1ns/1ps
`default_nettype none
module rerr_slip
   import rerr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic rx_frame_tick,
   input wire logic port_a_frame_edge,
   input wire logic port_b_frame_edge,
   input wire logic port_a_from_rx,
   input wire logic port_b_from_rx,
   input wire logic port_a_slave,
   input wire logic port_b_slave,
   output logic slip_evt_q
);

   logic [RERR_PHASE_W-1:0] phase_q;
   logic [RERR_PHASE_W-1:0] period_q;

   // port a wins when both ports take receiver data
   wire logic use_a = port_a_from_rx;
   wire logic use_b = port_b_from_rx & ~port_a_from_rx;
   wire logic sel_edge = use_a ? port_a_frame_edge :
                         use_b ? port_b_frame_edge : 1'b0;
   wire logic sel_slave = use_a ? port_a_slave :
                          use_b ? port_b_slave : 1'b0;

   wire logic [RERR_PHASE_W-1:0] lag = period_q - phase_q;
   wire logic [22:0] early_scaled = phase_q * RERR_PCT_FULL;
   wire logic [22:0] late_scaled = lag * RERR_PCT_FULL;
   wire logic [22:0] win_scaled = period_q * RERR_SLIP_WIN_PCT;
   wire logic in_window = (early_scaled < win_scaled) |
                          (late_scaled < win_scaled);
   wire logic [RERR_PHASE_W-1:0] phase_inc = (phase_q == RERR_PHASE_MAX) ?
                                             phase_q : phase_q + RERR_PHASE_ONE;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= '0;
         period_q <= '0;
         slip_evt_q <= 1'b0;
      end else begin
         phase_q <= rx_frame_tick ? '0 : phase_inc;
         if (rx_frame_tick) period_q <= phase_inc;
         slip_evt_q <= sel_edge & sel_slave & in_window;
      end
   end

endmodule : rerr_slip
`default_nettype wire

// ### logic/rerr_trig.sv
`timescale 1ns/1ps
`default_nettype none
module rerr_trig
   import rerr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic flag,
   input wire logic [1:0] mode,
   output logic hit
);

   logic prev_q;
   wire logic rise = flag & ~prev_q;
   wire logic fall = ~flag & prev_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) prev_q <= 1'b0;
      else prev_q <= flag;
   end

   // reserved mode never fires
   assign hit = (mode == RERR_TRIG_RISE) ? rise :
                (mode == RERR_TRIG_FALL) ? fall :
                (mode == RERR_TRIG_LEVEL) ? flag : 1'b0;

endmodule : rerr_trig
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rerr_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   rerr_req_t reg_req = '0;
   logic [7:0] reg_rdata_q;
   logic irq_q;
   logic cs_crc_fail = 1'b0, parity_fail = 1'b0, validity_in = 1'b0;
   logic biphase_fail = 1'b0, subcode_valid = 1'b0, subcode_crc_fail = 1'b0;
   logic [RERR_SUBCODE_W-1:0] subcode_data = '0;
   logic decoder_locked = 1'b1, recovery_pll_locked = 1'b1;
   logic xfer_start = 1'b0, xfer_done = 1'b0, rx_frame_tick = 1'b0;
   logic port_a_frame_edge = 1'b0, port_b_frame_edge = 1'b0;
   logic port_a_from_rx = 1'b0, port_b_from_rx = 1'b0;
   logic port_a_slave = 1'b0, port_b_slave = 1'b0;
   int mismatches = 0;
   int compares = 0;
   // level inputs {cs, parity, validity, biphase, dec unlock, pll unlock}
   logic [5:0] lv_in [8] = '{6'h00, 6'h20, 6'h10, 6'h08, 6'h04, 6'h02,
      6'h01, 6'h3f};
   logic [7:0] lv_exp [8] = '{8'h00, 8'h80, 8'h40, 8'h20, 8'h10, 8'h04,
      8'h04, 8'hf4};
   // {a fed, b fed, a slave, b slave, a offset, b offset, slip}
   int sl [7][7] = '{'{1, 0, 1, 0, 20, 99, 0}, '{1, 0, 1, 0, 1, 99, 1},
      '{1, 0, 0, 0, 1, 99, 0}, '{1, 1, 1, 1, 20, 1, 0},
      '{0, 1, 0, 1, 99, 1, 1}, '{0, 0, 1, 1, 1, 1, 0},
      '{1, 0, 1, 0, 0, 99, 1}};

   rerr_flags i_rerr_flags (.clk_sys, .rst_n, .reg_req, .reg_rdata_q,
      .cs_crc_fail, .parity_fail, .validity_in, .biphase_fail,
      .subcode_valid, .subcode_data, .subcode_crc_fail, .decoder_locked,
      .recovery_pll_locked, .xfer_start, .xfer_done, .rx_frame_tick,
      .port_a_frame_edge, .port_b_frame_edge, .port_a_from_rx,
      .port_b_from_rx, .port_a_slave, .port_b_slave, .irq_q);

   always #5 clk_sys = ~clk_sys;

   task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk_sys);
      reg_req.wr <= 1'b0;
   endtask : wr

   task automatic rdchk(input string what, input logic [7:0] a,
      input logic [7:0] exp);
      @(posedge clk_sys);
      reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clk_sys);
      reg_req.rd <= 1'b0;
      #1 chk(what, reg_rdata_q, exp);
   endtask : rdchk

   // counts the cycles with the interrupt high over the next n edges
   task automatic cnt_irq(input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge clk_sys);
         #1 if (irq_q === 1'b1) c++;
      end
   endtask : cnt_irq

   task automatic sc(input logic [RERR_SUBCODE_W-1:0] d, input logic crc);
      @(posedge clk_sys);
      subcode_valid <= 1'b1;
      subcode_data <= d;
      subcode_crc_fail <= crc;
      @(posedge clk_sys);
      subcode_valid <= 1'b0;
   endtask : sc

   // five frames of 40 cycles; an offset of 99 means no port edge
   task automatic frames(input int oa, input int ob, output int c);
      c = 0;
      for (int k = 0; k < 200; k++) begin
         @(posedge clk_sys);
         rx_frame_tick <= (k % 40 == 0);
         port_a_frame_edge <= (k % 40 == oa);
         port_b_frame_edge <= (k % 40 == ob);
         #1 if (irq_q === 1'b1) c++;
      end
   endtask : frames

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #100us;
      mismatches++;
      tally_and_finish();
   end

   initial begin
      int c;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      chk("irq after reset", {7'h00, irq_q}, 8'h00);
      rdchk("flags", RERR_ADDR_ERR_FLAGS, 8'h00);
      rdchk("slip", RERR_ADDR_SLIP_FLAG, 8'h00);
      rdchk("en1", RERR_ADDR_INT_EN1, 8'h00);
      rdchk("en2", RERR_ADDR_INT_EN2, 8'h00);
      rdchk("mode", RERR_ADDR_INT_MODE, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         {cs_crc_fail, parity_fail, validity_in, biphase_fail} <= lv_in[i][5:2];
         decoder_locked <= ~lv_in[i][1];
         recovery_pll_locked <= ~lv_in[i][0];
         repeat (3) @(posedge clk_sys);
         rdchk("level flags", 8'h14, lv_exp[i]);
      end
      @(posedge clk_sys);
      {cs_crc_fail, parity_fail, validity_in, biphase_fail} <= 4'h0;
      {decoder_locked, recovery_pll_locked} <= 2'h3;
      $display("level flag table done");
      wr(8'h16, 8'ha5);
      rdchk("en1 rw", 8'h16, 8'ha5);
      wr(8'h14, 8'hff);
      rdchk("flags ro", 8'h14, 8'h00);
      wr(8'h15, 8'hff);
      rdchk("slip ro", 8'h15, 8'h00);
      rdchk("unmapped", 8'h3c, 8'h00);
      wr(8'h16, 8'h00);
      $display("register access done");
      // an enabled flag fires once on the rise, a masked one stays quiet
      for (int e = 0; e < 3; e++) begin
         wr(8'h16, (e == 2) ? 8'h80 : (e == 1) ? 8'h10 : 8'h00);
         @(posedge clk_sys);
         biphase_fail <= 1'b1;
         cs_crc_fail <= (e == 2);
         cnt_irq(6, c);
         chk("rise irq", 8'(c), 8'(e > 0));
         @(posedge clk_sys);
         biphase_fail <= 1'b0;
         cs_crc_fail <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
      wr(8'h18, 8'h20);
      rdchk("mode rw", 8'h18, 8'h20);
      wr(8'h16, 8'h04);
      @(posedge clk_sys);
      decoder_locked <= 1'b0;
      cnt_irq(8, c);
      chk("level irq", 8'(c), 8'h07);
      @(posedge clk_sys);
      decoder_locked <= 1'b1;
      cnt_irq(4, c);
      chk("level irq off", {7'h00, irq_q}, 8'h00);
      wr(8'h18, 8'h01);
      wr(8'h16, 8'h01);
      @(posedge clk_sys);
      xfer_done <= 1'b1;
      @(posedge clk_sys);
      xfer_done <= 1'b0;
      cnt_irq(5, c);
      chk("fall irq on rise", 8'(c), 8'h00);
      rdchk("xfer done", 8'h14, 8'h01);
      @(posedge clk_sys);
      xfer_start <= 1'b1;
      @(posedge clk_sys);
      xfer_start <= 1'b0;
      cnt_irq(5, c);
      chk("fall irq", 8'(c), 8'h01);
      rdchk("xfer cleared", 8'h14, 8'h00);
      // switch to level mode while the flag already stands
      @(posedge clk_sys);
      xfer_done <= 1'b1;
      @(posedge clk_sys);
      xfer_done <= 1'b0;
      wr(8'h18, 8'h02);
      cnt_irq(6, c);
      chk("level irq buffer", 8'(c), 8'h06);
      @(posedge clk_sys);
      xfer_start <= 1'b1;
      @(posedge clk_sys);
      xfer_start <= 1'b0;
      cnt_irq(3, c);
      chk("level irq buffer off", {7'h00, irq_q}, 8'h00);
      wr(8'h18, 8'h0c);
      wr(8'h16, 8'h02);
      sc(80'h0000_0000_0000_0000_0000, 1'b1);
      cnt_irq(5, c);
      chk("reserved irq", 8'(c), 8'h00);
      rdchk("subcode crc", 8'h14, 8'h02);
      wr(8'h18, 8'h00);
      wr(8'h16, 8'h08);
      sc(80'h1234_0000_0000_0000_abcd, 1'b0);
      cnt_irq(5, c);
      chk("change irq", 8'(c), 8'h01);
      rdchk("subcode changed", 8'h14, 8'h08);
      sc(80'h1234_0000_0000_0000_abcd, 1'b0);
      rdchk("subcode same", 8'h14, 8'h00);
      $display("trigger mode tests done");
      wr(8'h16, 8'h00);
      wr(8'h17, 8'h01);
      // one idle run first, so the measured frame period is a real one
      frames(99, 99, c);
      for (int i = 0; i < 7; i++) begin
         @(posedge clk_sys);
         port_a_from_rx <= 1'(sl[i][0]);
         port_b_from_rx <= 1'(sl[i][1]);
         port_a_slave <= 1'(sl[i][2]);
         port_b_slave <= 1'(sl[i][3]);
         frames(sl[i][4], sl[i][5], c);
         chk("slip irq", 8'(c > 0), 8'(sl[i][6]));
         rdchk("slip flag", 8'h15, 8'(sl[i][6]));
      end
      wr(8'h17, 8'h00);
      @(posedge clk_sys);
      {port_a_from_rx, port_b_from_rx, port_a_slave, port_b_slave} <= 4'ha;
      frames(1, 99, c);
      chk("slip masked irq", 8'(c), 8'h00);
      rdchk("slip masked flag", 8'h15, 8'h01);
      rdchk("slip read clear", 8'h15, 8'h00);
      $display("slip tests done");
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
